// ==== kbc_host_cmd.sv ====
// Host-side status, config byte and command interpreter of a keyboard controller.
// Assumes serial engines on the same clock; host bus and pins are asynchronous.
// Functional notes
// (RULE_01) Status read with select high: bit0 output full, bit1 input full.
// (RULE_02) Status bit2 is zero after reset and mirrors config bit2.
// (RULE_03) Status bit3 is 1 after a command write, 0 after a data write.
// (RULE_04) Status bit4 is 0 while keyboard inhibited, 1 otherwise.
// (RULE_05) Bit5: transmit time-out in keyboard-only mode, mouse buffer full otherwise.
// (RULE_06) Bit6: receive time-out keyboard-only; any time-out in mouse-capable mode.
// (RULE_07) Bit7 set on parity error of last serial transfer.
// (RULE_08) Config bits 0 and 1 enable keyboard and mouse interrupt pins.
// (RULE_09) Config bit3 overrides inhibit; bit4 disables keyboard interface.
// (RULE_10) Config bit5: protocol check when 0 keyboard-only; mouse disable otherwise.
// (RULE_11) Config bit6 resets to 1 and enables scan translation; bit7 reserved.
// (RULE_12) 20h reads config byte to output buffer; 60h then data writes it.
// (RULE_13) AAh returns 55h, A9h and ABh return 00h, A4h returns F1h.
// (RULE_14) A7h/A8h set/clear config bit5 and aux clock pin in mouse-capable mode.
// (RULE_15) 9xh writes port pins 13..10; B0h-B7h clear, B8h-BFh set pins.
// (RULE_16) C1h copies pins 11..13, C2h pins 15..17, into status bits 5..7; in mouse-capable mode status bit5 stays the mouse buffer flag.
// (RULE_17) CAh returns mode on bit0: 1 mouse-capable, 0 keyboard-only.
// (RULE_18) D1h then data drives output port; C8h/C9h allow/block pins 22,23.
// (RULE_19) D2h/D3h then data loads output buffer with keyboard/mouse full flag.
// (RULE_20) D4h then data goes to the mouse serial interface.
// (RULE_21) E0h returns test inputs zero and one on bits 0 and 1.
// (RULE_22) Fxh pulses selected port pins 23..20 low for 6 microseconds.
// (RULE_23) All timing derives from the single clock input.
// (RULE_24) Self test answer and keyboard interrupt appear within 6 clocks.
// (RULE_25) Data writes not consumed by a command go to keyboard serial.
// (RULE_26) Input full sets on each host write, clears when byte consumed.
module kbc_host_cmd
    import kbc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    // Host parallel bus.
    input  wire logic       chipSel_n,
    input  wire logic       readStb_n,
    input  wire logic       writeStb_n,
    input  wire logic       cmd_data_select,
    input  wire logic [7:0] busDataIn,
    output logic      [7:0] busDataOut,
    output logic            busDataOe,
    // Device pins.
    input  wire logic [7:0] input_port_pins,
    input  wire logic       test_in_zero,
    input  wire logic       test_in_one,
    input  wire logic       mouse_capable_mode,
    output logic      [7:0] output_port_pins,
    output logic      [5:0] inPortOe,
    // Serial engine side.
    input  wire logic       rxValid,
    input  wire logic       rxFromAux,
    input  wire logic [7:0] rxData,
    input  wire logic       txTimeoutPulse,
    input  wire logic       rxTimeoutPulse,
    input  wire logic       parityErrPulse,
    input  wire logic       kbdInhibitIn,
    output logic            rxReady,
    output logic            kbdTxValid,
    output logic            auxTxValid,
    output logic      [7:0] txData,
    output logic            kbdIfOff,
    output logic            auxIfOff,
    output logic            protoCheck,
    output logic            scanXlate
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input port pin index for a B0h-BFh command, 0..5 for pins 10..15, 6/7 for 22/23.
    function automatic logic [2:0] pinIndex(input logic [2:0] sel);
        case (sel)
            3'h4:    pinIndex = 3'h6;
            3'h5:    pinIndex = 3'h7;
            3'h6:    pinIndex = 3'h4;
            3'h7:    pinIndex = 3'h5;
            default: pinIndex = sel;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Three-stage synchroniser; a bit is accepted once stages two and three agree.
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, acc_q, acc_d;
    logic              wrAct, wrActOld, rdAct, rdActOld, hostWr, hostRdEnd, selNew, modeAux;
    logic [7:0]        dataNew, pinsNew;
    logic              t0New, t1New;

    always_comb begin
        acc_d   = (s2_q & ~(s2_q ^ s3_q)) | (acc_q & (s2_q ^ s3_q));
        wrAct   = ~acc_d[22] & ~acc_d[20];
        rdAct   = ~acc_d[22] & ~acc_d[21];
        wrActOld = ~acc_q[22] & ~acc_q[20];
        rdActOld = ~acc_q[22] & ~acc_q[21];
        selNew  = acc_d[19];
        dataNew = acc_d[18:11];
        pinsNew = acc_q[10:3];
        t0New   = acc_q[2];
        t1New   = acc_q[1];
        modeAux = acc_q[0];
        hostWr  = wrAct & ~wrActOld;
        hostRdEnd = rdActOld & ~rdAct & ~acc_q[19];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            acc_q <= '1;
        end else if (clkEn) begin
            s1_q  <= {chipSel_n, readStb_n, writeStb_n, cmd_data_select, busDataIn,
                      input_port_pins, test_in_zero, test_in_one, mouse_capable_mode};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command interpreter and register state.
    kbc_state_e state_q, state_d;
    logic [7:0] cfg_q, cfg_d, obuf_q, obuf_d, ibuf_q, ibuf_d, pend_q, pend_d, outPort_q, outPort_d;
    logic [7:0] pulseCnt_q, pulseCnt_d, status, portPins;
    logic [5:0] inPort_q, inPort_d;
    logic [3:0] pulseSel_q, pulseSel_d;
    logic [2:0] errs_q, errs_d;
    logic       obf_q, obf_d, auxObf_q, auxObf_d, ibf_q, ibf_d, isCmd_q, isCmd_d;
    logic       lastCmd_q, lastCmd_d, wp_q, wp_d, kTx, aTx, rxTake, exec;

    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        obuf_d = obuf_q;
        ibuf_d = ibuf_q;
        pend_d = pend_q;
        outPort_d = outPort_q;
        pulseCnt_d = pulseCnt_q;
        inPort_d = inPort_q;
        pulseSel_d = pulseSel_q;
        errs_d = errs_q;
        obf_d = obf_q;
        auxObf_d = auxObf_q;
        ibf_d = ibf_q;
        isCmd_d = isCmd_q;
        lastCmd_d = lastCmd_q;
        wp_d = wp_q;
        kTx = 1'b0;
        aTx = 1'b0;
        rxTake = rxValid & rxReady & ~obf_q;
        exec = ibf_q & ~rxTake & (state_q != ST_PULSE);
        if (hostRdEnd) begin
            obf_d = 1'b0;
            auxObf_d = 1'b0;
        end
        if (rxTake) begin
            obuf_d = rxData;
            obf_d = 1'b1;
            auxObf_d = rxFromAux;
        end
        if (exec) begin
            ibf_d = 1'b0; // RULE_26
            if (!isCmd_q && state_q == ST_ARG) begin
                state_d = ST_IDLE;
                case (pend_q)
                    CMD_WR_CFG: cfg_d = ibuf_q; // RULE_12
                    CMD_WR_OUT: begin
                        outPort_d = ibuf_q; // RULE_18
                        if (!wp_q) begin
                            outPort_d[OP_ACLK] = outPort_q[OP_ACLK];
                            outPort_d[OP_ADAT] = outPort_q[OP_ADAT];
                        end
                    end
                    CMD_WR_KOB: begin
                        obuf_d = ibuf_q; // RULE_19
                        obf_d = 1'b1;
                        auxObf_d = 1'b0;
                    end
                    CMD_WR_AOB: begin
                        obuf_d = ibuf_q; // RULE_19
                        obf_d = 1'b1;
                        auxObf_d = 1'b1;
                    end
                    default: aTx = 1'b1; // RULE_20
                endcase
            end else if (!isCmd_q) begin
                kTx = 1'b1; // RULE_25
            end else begin
                state_d = ST_IDLE;
                obf_d = 1'b1;
                case (ibuf_q)
                    CMD_RD_CFG:  obuf_d = cfg_q; // RULE_12
                    CMD_VER_A, CMD_VER_B: obuf_d = VERSION_ID;
                    CMD_PASSWD:  obuf_d = ANS_PASSWD; // RULE_13
                    CMD_AUX_TST, CMD_KBD_TST: obuf_d = ANS_IF_OK; // RULE_13
                    CMD_SELF:    obuf_d = ANS_SELF_OK; // RULE_24
                    CMD_RD_IN:   obuf_d = pinsNew;
                    CMD_MODE:    obuf_d = {7'h00, modeAux}; // RULE_17
                    CMD_RD_OUT:  obuf_d = portPins;
                    CMD_RD_TEST: obuf_d = {6'h00, t1New, t0New}; // RULE_21
                    default:     obf_d = obf_q;
                endcase
                if (obf_d && !obf_q) auxObf_d = 1'b0;
                case (ibuf_q)
                    CMD_WR_CFG, CMD_WR_OUT, CMD_WR_KOB, CMD_WR_AOB, CMD_WR_AUX: begin
                        state_d = ST_ARG;
                        pend_d = ibuf_q;
                    end
                    CMD_AUX_OFF, CMD_AUX_ON: if (modeAux) begin
                        cfg_d[CF_ADIS] = (ibuf_q == CMD_AUX_OFF); // RULE_14
                        outPort_d[OP_ACLK] = (ibuf_q == CMD_AUX_OFF); // RULE_14
                    end
                    CMD_KBD_OFF: cfg_d[CF_KDIS] = 1'b1;
                    CMD_KBD_ON:  cfg_d[CF_KDIS] = 1'b0;
                    CMD_POLL_LO: errs_d = pinsNew[3:1]; // RULE_16
                    CMD_POLL_HI: errs_d = pinsNew[7:5]; // RULE_16
                    CMD_WP_EN:   wp_d = 1'b1; // RULE_18
                    CMD_WP_DIS:  wp_d = 1'b0; // RULE_18
                    default: begin
                        if (ibuf_q[7:4] == GRP_NIBBLE) inPort_d[3:0] = ibuf_q[3:0]; // RULE_15
                        if (ibuf_q[7:4] == GRP_PIN) begin
                            if (pinIndex(ibuf_q[2:0]) > 3'h5)
                                outPort_d[pinIndex(ibuf_q[2:0]) - 3'h4] = ibuf_q[3]; // RULE_15
                            else
                                inPort_d[pinIndex(ibuf_q[2:0])] = ibuf_q[3]; // RULE_15
                        end
                        if (ibuf_q[7:4] == GRP_EX && ibuf_q != CMD_RD_TEST) outPort_d[3:1] = ibuf_q[3:1];
                        if (ibuf_q[7:4] == GRP_PULSE && ibuf_q[3:0] != 4'h0) begin
                            state_d = ST_PULSE; // RULE_22
                            pulseSel_d = ibuf_q[3:0];
                            pulseCnt_d = PULSE_CNT;
                        end
                    end
                endcase
            end
        end
        if (state_q == ST_PULSE) begin
            pulseCnt_d = pulseCnt_q - 8'h01; // RULE_23
            if (pulseCnt_q == 8'h01) begin
                state_d = ST_IDLE;
                pulseSel_d = 4'h0;
            end
        end
        if (kTx || aTx) errs_d = 3'h0;
        if (txTimeoutPulse) errs_d[0] = ~modeAux; // RULE_05
        if (txTimeoutPulse && modeAux) errs_d[1] = 1'b1; // RULE_06
        if (rxTimeoutPulse) errs_d[1] = 1'b1; // RULE_06
        if (parityErrPulse) errs_d[2] = 1'b1; // RULE_07
        if (hostWr) begin
            ibf_d = 1'b1; // RULE_26
            ibuf_d = dataNew;
            isCmd_d = selNew;
            lastCmd_d = selNew; // RULE_03
        end
        portPins = outPort_d;
        portPins[OP_KIRQ] = cfg_d[CF_KIRQ] & obf_d & ~auxObf_d; // RULE_08
        portPins[OP_AIRQ] = cfg_d[CF_AIRQ] & auxObf_d; // RULE_08
        portPins[3:0] = portPins[3:0] & ~pulseSel_d; // RULE_22
        status[ST_OBF] = obf_d; // RULE_01
        status[ST_IBF] = ibf_d; // RULE_01
        status[ST_SYS] = cfg_d[CF_SYS]; // RULE_02
        status[ST_CMD] = lastCmd_d; // RULE_03
        status[ST_KEY] = ~kbdInhibitIn | cfg_d[CF_OVR]; // RULE_04 RULE_09
        status[5] = modeAux ? auxObf_d : errs_d[0]; // RULE_05
        status[7:6] = errs_d[2:1]; // RULE_06 RULE_07
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cfg_q <= CFG_RESET; // RULE_11
            obuf_q <= 8'h00;
            ibuf_q <= 8'h00;
            pend_q <= 8'h00;
            outPort_q <= OUTPORT_RESET;
            pulseCnt_q <= 8'h00;
            inPort_q <= INPORT_RESET;
            pulseSel_q <= 4'h0;
            errs_q <= 3'h0;
            obf_q <= 1'b0;
            auxObf_q <= 1'b0;
            ibf_q <= 1'b0;
            isCmd_q <= 1'b0;
            lastCmd_q <= 1'b0;
            wp_q <= 1'b0;
        end else if (clkEn) begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            obuf_q <= obuf_d;
            ibuf_q <= ibuf_d;
            pend_q <= pend_d;
            outPort_q <= outPort_d;
            pulseCnt_q <= pulseCnt_d;
            inPort_q <= inPort_d;
            pulseSel_q <= pulseSel_d;
            errs_q <= errs_d;
            obf_q <= obf_d;
            auxObf_q <= auxObf_d;
            ibf_q <= ibf_d;
            isCmd_q <= isCmd_d;
            lastCmd_q <= lastCmd_d;
            wp_q <= wp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busDataOut <= 8'h00;
            busDataOe <= 1'b0;
            output_port_pins <= OUTPORT_RESET & 8'hcf;
            inPortOe <= 6'h00;
            rxReady <= 1'b0;
            kbdTxValid <= 1'b0;
            auxTxValid <= 1'b0;
            txData <= 8'h00;
            kbdIfOff <= 1'b0;
            auxIfOff <= 1'b0;
            protoCheck <= 1'b0;
            scanXlate <= 1'b1;
        end else if (clkEn) begin
            busDataOut <= selNew ? status : obuf_d; // RULE_01
            busDataOe <= rdAct;
            output_port_pins <= portPins; // RULE_08
            inPortOe <= ~inPort_d;
            rxReady <= ~obf_d;
            kbdTxValid <= kTx; // RULE_25
            auxTxValid <= aTx; // RULE_20
            txData <= (kTx || aTx) ? ibuf_q : txData;
            kbdIfOff <= cfg_d[CF_KDIS]; // RULE_09
            auxIfOff <= modeAux & cfg_d[CF_ADIS]; // RULE_10
            protoCheck <= ~modeAux & ~cfg_d[CF_ADIS]; // RULE_10
            scanXlate <= cfg_d[CF_XLAT]; // RULE_11
        end
    end

endmodule // kbc_host_cmd

// ==== kbc_pkg.sv ====
// Constants for the keyboard controller host-side command logic.
// Assumes a single system clock; depends on no other files.
package kbc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PULSE_LOW_NS  = 6000;
    localparam int unsigned PULSE_CYC     = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  PULSE_CNT     = 8'(PULSE_CYC);
    localparam int unsigned SYNC_W        = 23;

    // Reset values and version answer.
    localparam logic [7:0] CFG_RESET     = 8'h40;
    localparam logic [7:0] OUTPORT_RESET = 8'hff;
    localparam logic [5:0] INPORT_RESET  = 6'h3f;
    localparam logic [7:0] VERSION_ID    = 8'h5a; // Arbitrary value.

    // Status field positions.
    localparam int unsigned ST_OBF  = 0;
    localparam int unsigned ST_IBF  = 1;
    localparam int unsigned ST_SYS  = 2;
    localparam int unsigned ST_CMD  = 3;
    localparam int unsigned ST_KEY  = 4;

    // Config byte field positions.
    localparam int unsigned CF_KIRQ = 0;
    localparam int unsigned CF_AIRQ = 1;
    localparam int unsigned CF_SYS  = 2;
    localparam int unsigned CF_OVR  = 3;
    localparam int unsigned CF_KDIS = 4;
    localparam int unsigned CF_ADIS = 5;
    localparam int unsigned CF_XLAT = 6;

    // Output port pin positions.
    localparam int unsigned OP_ADAT = 2;
    localparam int unsigned OP_ACLK = 3;
    localparam int unsigned OP_KIRQ = 4;
    localparam int unsigned OP_AIRQ = 5;

    // Command codes.
    localparam logic [7:0] CMD_RD_CFG  = 8'h20;
    localparam logic [7:0] CMD_WR_CFG  = 8'h60;
    localparam logic [7:0] CMD_VER_A   = 8'ha1;
    localparam logic [7:0] CMD_PASSWD  = 8'ha4;
    localparam logic [7:0] CMD_AUX_OFF = 8'ha7;
    localparam logic [7:0] CMD_AUX_ON  = 8'ha8;
    localparam logic [7:0] CMD_AUX_TST = 8'ha9;
    localparam logic [7:0] CMD_SELF    = 8'haa;
    localparam logic [7:0] CMD_KBD_TST = 8'hab;
    localparam logic [7:0] CMD_KBD_OFF = 8'had;
    localparam logic [7:0] CMD_KBD_ON  = 8'hae;
    localparam logic [7:0] CMD_VER_B   = 8'haf;
    localparam logic [7:0] CMD_RD_IN   = 8'hc0;
    localparam logic [7:0] CMD_POLL_LO = 8'hc1;
    localparam logic [7:0] CMD_POLL_HI = 8'hc2;
    localparam logic [7:0] CMD_WP_EN   = 8'hc8;
    localparam logic [7:0] CMD_WP_DIS  = 8'hc9;
    localparam logic [7:0] CMD_MODE    = 8'hca;
    localparam logic [7:0] CMD_RD_OUT  = 8'hd0;
    localparam logic [7:0] CMD_WR_OUT  = 8'hd1;
    localparam logic [7:0] CMD_WR_KOB  = 8'hd2;
    localparam logic [7:0] CMD_WR_AOB  = 8'hd3;
    localparam logic [7:0] CMD_WR_AUX  = 8'hd4;
    localparam logic [7:0] CMD_RD_TEST = 8'he0;
    localparam logic [3:0] GRP_NIBBLE  = 4'h9;
    localparam logic [3:0] GRP_EX      = 4'he;
    localparam logic [3:0] GRP_PULSE   = 4'hf;
    localparam logic [3:0] GRP_PIN     = 4'hb;

    // Answers.
    localparam logic [7:0] ANS_SELF_OK = 8'h55;
    localparam logic [7:0] ANS_IF_OK   = 8'h00;
    localparam logic [7:0] ANS_PASSWD  = 8'hf1;

    typedef enum logic [1:0] {ST_IDLE, ST_ARG, ST_PULSE} kbc_state_e;
endpackage

// ==== kbc_host_cmd_sva.sv ====
// Port-level assertions for the keyboard controller host command logic.
// Assumes one clock and a synchronous active-low reset; bound below.
module kbc_host_cmd_sva
    import kbc_pkg::*;
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rst_n,
    // Host bus.
    input wire logic       chipSel_n,
    input wire logic       readStb_n,
    input wire logic       writeStb_n,
    input wire logic       busDataOe,
    // Pins and serial side.
    input wire logic [7:0] output_port_pins,
    input wire logic [5:0] inPortOe,
    input wire logic       kbdTxValid,
    input wire logic       auxTxValid,
    input wire logic [7:0] txData,
    input wire logic       scanXlate
);
    default clocking cb @(posedge clk);
    endclocking

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] lowCnt_q, lowCnt_d;
    always_comb begin
        lowCnt_d = 8'h00;
        if (!output_port_pins[0]) lowCnt_d = (lowCnt_q == 8'hff) ? lowCnt_q : lowCnt_q + 8'h01;
    end
    always_ff @(posedge clk) begin
        lowCnt_q <= rst_n ? lowCnt_d : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    reset_vals_a: assert property (!rst_n |=> !busDataOe && inPortOe == 6'h00
        && output_port_pins == 8'hcf && scanXlate && !kbdTxValid && !auxTxValid)
        else $error("outputs not at reset values");
    read_answer_a: assert property (disable iff (!rst_n)
        $fell(readStb_n) && !chipSel_n |-> ##[3:6] busDataOe)
        else $error("read not answered in time");
    read_cause_a: assert property (disable iff (!rst_n)
        $rose(busDataOe) |-> $past(!readStb_n && !chipSel_n, 3))
        else $error("bus driven without a read");
    read_release_a: assert property (disable iff (!rst_n)
        $rose(readStb_n) |-> ##[3:6] !busDataOe)
        else $error("bus still driven after read end");
    pulse_width_a: assert property (disable iff (!rst_n)
        $rose(output_port_pins[0]) |-> lowCnt_q == PULSE_CNT)
        else $error("port pin pulse has wrong width");
    tx_single_a: assert property (disable iff (!rst_n)
        kbdTxValid || auxTxValid |=> !kbdTxValid && !auxTxValid && $stable(txData))
        else $error("transmit request not a single pulse");
    tx_route_a: assert property (disable iff (!rst_n) !(kbdTxValid && auxTxValid))
        else $error("byte sent to both serial sides");
    inport_cause_a: assert property (disable iff (!rst_n)
        !$stable(inPortOe) |-> $past(!writeStb_n, 2))
        else $error("open drain enables changed without a write");
    aux_tx_c: cover property (auxTxValid);
    kbd_tx_c: cover property (kbdTxValid);
    pulse_end_c: cover property ($rose(output_port_pins[0]));
endmodule // kbc_host_cmd_sva

bind kbc_host_cmd kbc_host_cmd_sva i_kbc_host_cmd_sva (.clk(clk), .rst_n(rst_n), .chipSel_n(chipSel_n),
    .readStb_n(readStb_n), .writeStb_n(writeStb_n), .busDataOe(busDataOe), .output_port_pins(output_port_pins),
    .inPortOe(inPortOe), .kbdTxValid(kbdTxValid), .auxTxValid(auxTxValid), .txData(txData), .scanXlate(scanXlate));

// ==== kbc_host_model.sv ====
// Host processor model on the controller's parallel command/data bus.
// Assumes the bench calls one task at a time on the shared clock.
module kbc_host_model (
    // Clock.
    input  wire logic       clk,
    // Bus to the controller.
    output logic            chipSel_n,
    output logic            readStb_n,
    output logic            writeStb_n,
    output logic            cmd_data_select,
    output logic      [7:0] busDataIn,
    input  wire logic [7:0] busDataOut,
    input  wire logic       busDataOe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        chipSel_n = 1'b1;
        readStb_n = 1'b1;
        writeStb_n = 1'b1;
        cmd_data_select = 1'b1;
        busDataIn = 8'h00;
    end

    task automatic wr(input logic sel, input logic [7:0] d);
        @(posedge clk);
        chipSel_n <= 1'b0;
        writeStb_n <= 1'b0;
        cmd_data_select <= sel;
        busDataIn <= d;
        repeat (8) @(posedge clk);
        chipSel_n <= 1'b1;
        writeStb_n <= 1'b1;
        busDataIn <= ~d;
        repeat (10) @(posedge clk);
    endtask

    task automatic rd(input logic sel, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        chipSel_n <= 1'b0;
        readStb_n <= 1'b0;
        cmd_data_select <= sel;
        for (int i = 0; i < 12 && !ok; i++) begin
            @(posedge clk);
            if (busDataOe === 1'b1) begin
                ok = 1'b1;
                d = busDataOut;
            end
        end
        chipSel_n <= 1'b1;
        readStb_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule // kbc_host_model

// ==== tb_kbc_host_cmd.sv ====
// Self-checking bench for the keyboard controller host command logic.
// Assumes the host model drives the bus; serial side driven here.
module tb_kbc_host_cmd
    import kbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, mode = 1'b1;
    logic       chipSel_n, readStb_n, writeStb_n, cmdSel, busDataOe, inhibit = 1'b0;
    logic [7:0] busDataIn, busDataOut, extPins = 8'hff, portPins, txData, pinLevel;
    logic [5:0] inPortOe;
    logic       rxValid = 1'b0, rxFromAux = 1'b0, rxReady, kbdTxValid, auxTxValid;
    logic [7:0] rxData = 8'h00, kbdSeen = 8'hff, auxSeen = 8'hff;
    logic       txTo = 1'b0, rxTo = 1'b0, parErr = 1'b0;
    int         n_errors = 0, n_compared = 0;
    logic [7:0] ansCmd [5] = '{CMD_AUX_TST, CMD_KBD_TST, CMD_PASSWD, CMD_MODE, CMD_RD_TEST};
    logic [7:0] ansExp [5] = '{8'h00, 8'h00, 8'hf1, 8'h01, 8'h01};

    always #50 clk = ~clk;
    assign pinLevel = extPins & {2'b11, ~inPortOe};

    kbc_host_cmd i_kbc_host_cmd (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .chipSel_n(chipSel_n),
        .readStb_n(readStb_n), .writeStb_n(writeStb_n), .cmd_data_select(cmdSel), .busDataIn(busDataIn),
        .busDataOut(busDataOut), .busDataOe(busDataOe), .input_port_pins(pinLevel), .test_in_zero(1'b1),
        .test_in_one(1'b0), .mouse_capable_mode(mode), .output_port_pins(portPins), .inPortOe(inPortOe),
        .rxValid(rxValid), .rxFromAux(rxFromAux), .rxData(rxData), .txTimeoutPulse(txTo),
        .rxTimeoutPulse(rxTo), .parityErrPulse(parErr), .kbdInhibitIn(inhibit), .rxReady(rxReady),
        .kbdTxValid(kbdTxValid), .auxTxValid(auxTxValid), .txData(txData), .kbdIfOff(), .auxIfOff(),
        .protoCheck(), .scanXlate());
    kbc_host_model i_kbc_host_model (.clk(clk), .chipSel_n(chipSel_n), .readStb_n(readStb_n),
        .writeStb_n(writeStb_n), .cmd_data_select(cmdSel), .busDataIn(busDataIn), .busDataOut(busDataOut),
        .busDataOe(busDataOe));

    always @(posedge clk) begin
        if (kbdTxValid === 1'b1) kbdSeen <= txData;
        if (auxTxValid === 1'b1) auxSeen <= txData;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hw(input logic s, input logic [7:0] d);
        i_kbc_host_model.wr(s, d);
    endtask

    task automatic rdChk(input logic s, input logic [7:0] mask, input logic [7:0] exp, input string what);
        logic [7:0] d;
        bit         ok;
        i_kbc_host_model.rd(s, d, ok);
        if (!ok) begin
            n_errors++;
            $display("ERROR %s expected bus driven seen none", what);
            end_sim();
        end
        chk(what, exp, d & mask);
    endtask

    task automatic st(input logic [7:0] mask, input logic [7:0] exp);
        rdChk(1'b1, mask, exp, "status");
    endtask

    task automatic cmdRd(input logic [7:0] c, input logic [7:0] exp);
        hw(1'b1, c);
        rdChk(1'b0, 8'hff, exp, "command answer");
    endtask

    task automatic pins(input logic [7:0] exp);
        chk("port pins low nibble", exp, {4'h0, portPins[3:0]});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        st(8'hf7, 8'h10);
        hw(1'b1, CMD_RD_CFG);
        st(8'h0b, 8'h09);
        rdChk(1'b0, 8'hff, CFG_RESET, "config byte");
        hw(1'b1, CMD_WR_CFG);
        hw(1'b0, 8'h05);
        st(8'h0f, 8'h04);
        cmdRd(CMD_RD_CFG, 8'h05);
        hw(1'b1, CMD_SELF);
        chk("keyboard irq pin", 8'h10, portPins & 8'h10);
        rdChk(1'b0, 8'hff, 8'h55, "self test");
        foreach (ansCmd[i]) cmdRd(ansCmd[i], ansExp[i]);
        $display("test config and answers done");
        hw(1'b1, CMD_WR_KOB);
        hw(1'b0, 8'ha5);
        rdChk(1'b0, 8'hff, 8'ha5, "keyboard buffer");
        hw(1'b1, CMD_WR_AOB);
        hw(1'b0, 8'h3c);
        st(8'h21, 8'h21);
        rdChk(1'b0, 8'hff, 8'h3c, "mouse buffer");
        hw(1'b1, CMD_AUX_ON);
        chk("aux clock pin", 8'h00, portPins & 8'h08);
        cmdRd(CMD_RD_CFG, 8'h05);
        hw(1'b1, CMD_AUX_OFF);
        chk("aux clock pin", 8'h08, portPins & 8'h08);
        cmdRd(CMD_RD_CFG, 8'h25);
        $display("test buffers and mouse enable done");
        hw(1'b1, CMD_WP_EN);
        hw(1'b1, CMD_WR_OUT);
        hw(1'b0, 8'h07);
        pins(8'h07);
        hw(1'b1, 8'hb4);
        pins(8'h03);
        hw(1'b1, 8'hbc);
        pins(8'h07);
        hw(1'b1, 8'hf1);
        pins(8'h06);
        repeat (70) @(posedge clk);
        pins(8'h07);
        hw(1'b1, CMD_WP_DIS);
        hw(1'b1, CMD_WR_OUT);
        hw(1'b0, 8'h00);
        pins(8'h04);
        extPins <= 8'h08;
        hw(1'b1, CMD_POLL_LO);
        st(8'hc0, 8'h80);
        extPins <= 8'h40;
        hw(1'b1, CMD_POLL_HI);
        st(8'hc0, 8'h40);
        hw(1'b1, 8'h95);
        chk("open drain enables", 8'h0a, {4'h0, inPortOe[3:0]});
        $display("test port pins done");
        hw(1'b1, CMD_WR_AUX);
        hw(1'b0, 8'h77);
        chk("mouse tx byte", 8'h77, auxSeen);
        chk("keyboard tx byte", 8'hff, kbdSeen);
        rxTo <= 1'b1;
        parErr <= 1'b1;
        @(posedge clk);
        rxTo <= 1'b0;
        parErr <= 1'b0;
        st(8'hc0, 8'hc0);
        hw(1'b0, 8'h5a);
        chk("keyboard tx byte", 8'h5a, kbdSeen);
        st(8'hc0, 8'h00);
        txTo <= 1'b1;
        @(posedge clk);
        txTo <= 1'b0;
        st(8'hc0, 8'h40);
        rxFromAux <= 1'b1;
        rxData <= 8'h6b;
        rxValid <= 1'b1;
        @(posedge clk);
        rxValid <= 1'b0;
        st(8'h21, 8'h21);
        rdChk(1'b0, 8'hff, 8'h6b, "mouse receive byte");
        inhibit <= 1'b1;
        st(8'h10, 8'h00);
        mode <= 1'b0;
        cmdRd(CMD_MODE, 8'h00);
        hw(1'b1, CMD_AUX_ON);
        cmdRd(CMD_RD_CFG, 8'h25);
        txTo <= 1'b1;
        @(posedge clk);
        txTo <= 1'b0;
        st(8'h20, 8'h20);
        $display("test serial side done");
        end_sim();
    end
endmodule // tb_kbc_host_cmd
